// ### rtl/aux_timer_pkg.sv
// Constants and carrier types of the auxiliary timer and capture/reload block
package aux_timer_pkg;
   // Register addresses
   localparam logic [15:0] ADDR_AUX_IRQ = 16'hff66;
   localparam logic [15:0] ADDR_CAP_IRQ = 16'hff6a;
   localparam logic [15:0] ADDR_CORE_IRQ = 16'hff68;
   localparam logic [15:0] ADDR_CORE_CTRL = 16'hff48;
   localparam logic [15:0] ADDR_AUX_CTRL = 16'hff4a;
   localparam logic [15:0] ADDR_CORE_TIMER = 16'hfe48;
   localparam logic [15:0] ADDR_AUX_TIMER = 16'hfe46;
   localparam logic [15:0] ADDR_CAP_RELOAD = 16'hfe4a;
   // Reset values
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] TIMER_RESET = 16'h0000;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   // Writable bits; reserved bits read as zero
   localparam logic [15:0] AUX_CTRL_MASK = 16'hf0cf;
   localparam logic [15:0] CORE_CTRL_MASK = 16'h86c7;
   // Wrap limits
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] CNT_MIN = 16'h0000;
   // Prescaler base divisor 8, largest 1024
   localparam int PRE_W = 10;
   localparam logic [PRE_W:0] PRE_BASE = 11'h008;

   typedef struct packed {
      logic capture_enable;
      logic clear_on_capture;
      logic [1:0] capture_edge_select;
      logic [3:0] rsv_hi;
      logic aux_count_down;
      logic aux_run;
      logic [1:0] rsv_lo;
      logic aux_counter_mode_sel;
      logic [2:0] aux_input_select;
   } aux_ctrl_t;

   typedef struct packed {
      logic reload_enable;
      logic [3:0] rsv_hi;
      logic core_toggle_latch;
      logic core_toggle_out_enable;
      logic rsv_mid;
      logic core_count_down;
      logic core_run;
      logic [2:0] rsv_lo;
      logic [2:0] core_input_select;
   } core_ctrl_t;

   typedef struct packed {
      logic request;
      logic irq_enable;
      logic [5:0] level;
   } irq_ctrl_t;
endpackage

// ### rtl/aux_timer_capture_reload.sv
// Auxiliary up/down timer with capture/reload register and chained core timer
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
// Operation
// - Timer mode counts system clock through eight prescaler options picked by input select.
// - Prescaler divides by eight times two to the input select, 8 to 1024.
// - Counter mode steps only on toggle latch changes caused by core timer wraps.
// - Software writes to the toggle latch never step the auxiliary timer.
// - Counter select: top bit 0 or low 00 off; 01 rise, 10 fall, 11 both.
// - Core toggle latch inverts on every core timer wrap.
// - Auxiliary timer counts only while running; direction bit picks up or down.
// - Core and auxiliary directions are independent for a 32 or 33 bit chain.
// - Auxiliary wrap FFFF to 0000 up, or 0000 to FFFF down, sets its request.
// - Auxiliary request reaches the vector output only while its enable is set.
// - Sixteen bit capture/reload register: capture target, reload source, or both.
// - Capture enable bit allows capture; trigger comes from capture pin edges.
// - Capture edge field: 00 none, 01 rising, 10 falling, 11 both edges.
// - Selected edge with capture enabled copies auxiliary timer and sets capture request.
// - Clear-on-capture resets auxiliary timer to 0000 on selected edge, capture or not.
// - Selected edge sets capture request even with capture disabled.
// - Capture request reaches the vector output only while its enable is set.
// - With reload enabled a core wrap loads capture/reload register into core timer.
// - Reload leaves capture request alone; core wrap request still set.
// - Capture and reload work independently and may be active together.
module aux_timer_capture_reload
   import aux_timer_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Register port
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rd_data,
   // Capture pin
   input wire logic i_capture_input_pin,
   // Service requests and toggle output
   output logic o_aux_wrap_vector,
   output logic o_capture_vector,
   output logic o_core_wrap_vector,
   output logic o_core_toggle_out_pin
);

   // Prescaler tick: low 3+sel bits of the free counter all ones
   function automatic logic pre_tick(input logic [PRE_W-1:0] cnt, input logic [2:0] sel);
      logic [PRE_W-1:0] mask;
      mask = PRE_W'((PRE_BASE << sel) - 11'h001);
      return (cnt & mask) == mask;
   endfunction

   // Edge select shared by counter mode and capture: bit0 rise, bit1 fall
   function automatic logic edge_hit(input logic rise, input logic fall, input logic [1:0] sel);
      return (rise & sel[0]) | (fall & sel[1]);
   endfunction

   // Wrap condition of a 16-bit up/down counter
   function automatic logic at_limit(input logic [15:0] v, input logic down);
      return down ? (v == CNT_MIN) : (v == CNT_MAX);
   endfunction

   function automatic logic [15:0] step(input logic [15:0] v, input logic down);
      return down ? v - 16'h0001 : v + 16'h0001;
   endfunction

   aux_ctrl_t aux_ctrl_q;
   aux_ctrl_t aux_ctrl_d;
   core_ctrl_t core_ctrl_q;
   core_ctrl_t core_ctrl_d;
   irq_ctrl_t aux_irq_q;
   irq_ctrl_t aux_irq_d;
   irq_ctrl_t cap_irq_q;
   irq_ctrl_t cap_irq_d;
   irq_ctrl_t core_irq_q;
   irq_ctrl_t core_irq_d;
   logic [15:0] aux_timer_q;
   logic [15:0] aux_timer_d;
   logic [15:0] core_timer_q;
   logic [15:0] core_timer_d;
   logic [15:0] capture_reload_q;
   logic [15:0] capture_reload_d;
   logic [PRE_W-1:0] pre_cnt_q;
   logic pin_s1_q;
   logic pin_s2_q;
   logic pin_s3_q;
   logic pin_lvl_q;
   logic [15:0] rd_data_q;
   logic aux_vec_q;
   logic cap_vec_q;
   logic core_vec_q;
   logic toggle_pin_q;

   // Address decode
   wire sel_aux_irq = i_addr == ADDR_AUX_IRQ;
   wire sel_cap_irq = i_addr == ADDR_CAP_IRQ;
   wire sel_core_irq = i_addr == ADDR_CORE_IRQ;
   wire sel_core_ctrl = i_addr == ADDR_CORE_CTRL;
   wire sel_aux_ctrl = i_addr == ADDR_AUX_CTRL;
   wire sel_core_tmr = i_addr == ADDR_CORE_TIMER;
   wire sel_aux_tmr = i_addr == ADDR_AUX_TIMER;
   wire sel_cap_rel = i_addr == ADDR_CAP_RELOAD;

   // Core timer wrap and toggle latch
   wire core_tick = pre_tick(pre_cnt_q, core_ctrl_q.core_input_select);
   wire core_step = core_ctrl_q.core_run & core_tick;
   wire core_wrap = core_step & at_limit(core_timer_q, core_ctrl_q.core_count_down);
   // Only wrap-caused toggles feed the chain; software writes never do
   wire tl_rise = core_wrap & ~core_ctrl_q.core_toggle_latch;
   wire tl_fall = core_wrap & core_ctrl_q.core_toggle_latch;

   // Auxiliary count source
   wire aux_tmr_tick = pre_tick(pre_cnt_q, aux_ctrl_q.aux_input_select);
   wire aux_cnt_tick = aux_ctrl_q.aux_input_select[2] &
      edge_hit(tl_rise, tl_fall, aux_ctrl_q.aux_input_select[1:0]);
   wire aux_src = aux_ctrl_q.aux_counter_mode_sel ? aux_cnt_tick : aux_tmr_tick;
   wire aux_step = aux_ctrl_q.aux_run & aux_src;
   wire aux_wrap = aux_step & at_limit(aux_timer_q, aux_ctrl_q.aux_count_down);

   // Capture pin edges from the stable, agreed level
   wire pin_settled = pin_s2_q == pin_s3_q;
   wire pin_change = pin_settled & (pin_s3_q != pin_lvl_q);
   wire pin_rise = pin_change & pin_s3_q;
   wire pin_fall = pin_change & ~pin_s3_q;
   wire cap_edge = edge_hit(pin_rise, pin_fall, aux_ctrl_q.capture_edge_select);
   wire do_capture = cap_edge & aux_ctrl_q.capture_enable;
   wire do_clear = cap_edge & aux_ctrl_q.clear_on_capture;

   wire wr_aux_irq = i_wr & sel_aux_irq;
   wire wr_cap_irq = i_wr & sel_cap_irq;
   wire wr_core_irq = i_wr & sel_core_irq;
   wire wr_aux_ctrl = i_wr & sel_aux_ctrl;
   wire wr_core_ctrl = i_wr & sel_core_ctrl;
   wire wr_aux_tmr = i_wr & sel_aux_tmr;
   wire wr_core_tmr = i_wr & sel_core_tmr;
   wire wr_cap_rel = i_wr & sel_cap_rel;

   // Control registers
   always_comb begin
      aux_ctrl_d = aux_ctrl_q;
      if (wr_aux_ctrl) begin
         aux_ctrl_d = aux_ctrl_t'(i_wr_data & AUX_CTRL_MASK);
      end
   end

   always_comb begin
      core_ctrl_d = core_ctrl_q;
      if (wr_core_ctrl) begin
         core_ctrl_d = core_ctrl_t'(i_wr_data & CORE_CTRL_MASK);
      end
      if (core_wrap) begin
         core_ctrl_d.core_toggle_latch = ~core_ctrl_d.core_toggle_latch;
      end
   end

   // Interrupt control registers; a hardware set wins over a software clear
   always_comb begin
      aux_irq_d = aux_irq_q;
      if (wr_aux_irq) begin
         aux_irq_d = irq_ctrl_t'(i_wr_data[7:0]);
      end
      if (aux_wrap) begin
         aux_irq_d.request = 1'b1;
      end
   end

   always_comb begin
      cap_irq_d = cap_irq_q;
      if (wr_cap_irq) begin
         cap_irq_d = irq_ctrl_t'(i_wr_data[7:0]);
      end
      // Set on every selected edge, captured or not; reload never touches it
      if (cap_edge) begin
         cap_irq_d.request = 1'b1;
      end
   end

   always_comb begin
      core_irq_d = core_irq_q;
      if (wr_core_irq) begin
         core_irq_d = irq_ctrl_t'(i_wr_data[7:0]);
      end
      if (core_wrap) begin
         core_irq_d.request = 1'b1;
      end
   end

   // Auxiliary timer: clear beats count and software write
   always_comb begin
      aux_timer_d = aux_timer_q;
      if (wr_aux_tmr) begin
         aux_timer_d = i_wr_data;
      end else if (aux_step) begin
         aux_timer_d = step(aux_timer_q, aux_ctrl_q.aux_count_down);
      end
      if (do_clear) begin
         aux_timer_d = TIMER_RESET;
      end
   end

   // Core timer with optional reload on wrap
   always_comb begin
      core_timer_d = core_timer_q;
      if (wr_core_tmr) begin
         core_timer_d = i_wr_data;
      end else if (core_wrap && core_ctrl_q.reload_enable) begin
         core_timer_d = capture_reload_q;
      end else if (core_step) begin
         core_timer_d = step(core_timer_q, core_ctrl_q.core_count_down);
      end
   end

   // Capture/reload register; capture wins over software write
   always_comb begin
      capture_reload_d = capture_reload_q;
      if (wr_cap_rel) begin
         capture_reload_d = i_wr_data;
      end
      if (do_capture) begin
         capture_reload_d = aux_timer_q;
      end
   end

   // Read selection
   wire [15:0] rd_mux =
      sel_aux_irq ? {8'h00, aux_irq_q} :
      sel_cap_irq ? {8'h00, cap_irq_q} :
      sel_core_irq ? {8'h00, core_irq_q} :
      sel_aux_ctrl ? 16'(aux_ctrl_q) :
      sel_core_ctrl ? 16'(core_ctrl_q) :
      sel_aux_tmr ? aux_timer_q :
      sel_core_tmr ? core_timer_q :
      sel_cap_rel ? capture_reload_q : 16'h0000;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         aux_ctrl_q <= aux_ctrl_t'(CTRL_RESET);
      end else begin
         aux_ctrl_q <= aux_ctrl_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         core_ctrl_q <= core_ctrl_t'(CTRL_RESET);
      end else begin
         core_ctrl_q <= core_ctrl_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         aux_irq_q <= irq_ctrl_t'(IRQ_RESET);
      end else begin
         aux_irq_q <= aux_irq_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cap_irq_q <= irq_ctrl_t'(IRQ_RESET);
      end else begin
         cap_irq_q <= cap_irq_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         core_irq_q <= irq_ctrl_t'(IRQ_RESET);
      end else begin
         core_irq_q <= core_irq_d;
      end
   end

   // Timers, capture/reload register and shared free prescaler
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         aux_timer_q <= TIMER_RESET;
      end else begin
         aux_timer_q <= aux_timer_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         core_timer_q <= TIMER_RESET;
      end else begin
         core_timer_q <= core_timer_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         capture_reload_q <= TIMER_RESET;
      end else begin
         capture_reload_q <= capture_reload_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pre_cnt_q <= '0;
      end else begin
         pre_cnt_q <= pre_cnt_q + PRE_W'(1);
      end
   end

   // Pin synchroniser
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= i_capture_input_pin;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // Settled level: a change counts once stages two and three agree
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pin_lvl_q <= 1'b0;
      end else if (pin_settled) begin
         pin_lvl_q <= pin_s3_q;
      end
   end

   // Output next values
   wire [15:0] rd_nxt = i_rd ? rd_mux : 16'h0000;
   wire aux_vec_d = aux_irq_d.request & aux_irq_d.irq_enable;
   wire cap_vec_d = cap_irq_d.request & cap_irq_d.irq_enable;
   wire core_vec_d = core_irq_d.request & core_irq_d.irq_enable;
   wire toggle_pin_d = core_ctrl_d.core_toggle_latch & core_ctrl_d.core_toggle_out_enable;

   // Outputs, each straight from a flip-flop
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rd_data_q <= 16'h0000;
      end else begin
         rd_data_q <= rd_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         aux_vec_q <= 1'b0;
      end else begin
         aux_vec_q <= aux_vec_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cap_vec_q <= 1'b0;
      end else begin
         cap_vec_q <= cap_vec_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         core_vec_q <= 1'b0;
      end else begin
         core_vec_q <= core_vec_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         toggle_pin_q <= 1'b0;
      end else begin
         toggle_pin_q <= toggle_pin_d;
      end
   end

   assign o_rd_data = rd_data_q;
   assign o_aux_wrap_vector = aux_vec_q;
   assign o_capture_vector = cap_vec_q;
   assign o_core_wrap_vector = core_vec_q;
   assign o_core_toggle_out_pin = toggle_pin_q;

endmodule // aux_timer_capture_reload

// ### verification/aux_timer_capture_reload_assertions.sv
// Port-level checker for the auxiliary timer and capture/reload block
`timescale 1ns/10ps
module aux_timer_capture_reload_assertions
   import aux_timer_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Register port
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rd_data,
   // Pin and service requests
   input wire logic i_capture_input_pin,
   input wire logic o_aux_wrap_vector,
   input wire logic o_capture_vector,
   input wire logic o_core_wrap_vector,
   input wire logic o_core_toggle_out_pin
);
   logic prev_pin_q;
   logic [3:0] pin_age_q;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   // Cycles since the capture pin last changed
   always_ff @(posedge i_clk_sys) begin
      prev_pin_q <= i_capture_input_pin;
      if (i_rst || i_capture_input_pin != prev_pin_q) begin
         pin_age_q <= i_rst ? 4'hf : 4'h0;
      end else if (pin_age_q != 4'hf) begin
         pin_age_q <= pin_age_q + 4'h1;
      end
   end
   sequence s_rd_of(logic [15:0] a);
      i_rd && i_addr == a;
   endsequence
   property p_rd_idle;
      !i_rd |=> o_rd_data == 16'h0000;
   endproperty
   property p_aux_upper;
      s_rd_of(ADDR_AUX_IRQ) |=> o_rd_data[15:8] == 8'h00;
   endproperty
   property p_cap_upper;
      s_rd_of(ADDR_CAP_IRQ) |=> o_rd_data[15:8] == 8'h00;
   endproperty
   property p_ctrl_rsv;
      s_rd_of(ADDR_AUX_CTRL) |=> (o_rd_data & ~AUX_CTRL_MASK) == 16'h0000;
   endproperty
   property p_aux_fell;
      $fell(o_aux_wrap_vector) |-> $past(i_wr && i_addr == ADDR_AUX_IRQ, 1);
   endproperty
   property p_cap_fell;
      $fell(o_capture_vector) |-> $past(i_wr && i_addr == ADDR_CAP_IRQ, 1);
   endproperty
   property p_core_fell;
      $fell(o_core_wrap_vector) |-> $past(i_wr && i_addr == ADDR_CORE_IRQ, 1);
   endproperty
   property p_cap_rise;
      $rose(o_capture_vector) |-> pin_age_q <= 4'h8 || $past(i_wr && i_addr == ADDR_CAP_IRQ, 1);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
   a_aux_upper: assert property (p_aux_upper) else $error("aux irq control upper byte set");
   a_cap_upper: assert property (p_cap_upper) else $error("capture irq control upper byte set");
   a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("aux control reserved bit set");
   a_aux_fell: assert property (p_aux_fell) else $error("aux vector dropped without write");
   a_cap_fell: assert property (p_cap_fell) else $error("capture vector dropped without write");
   a_core_fell: assert property (p_core_fell) else $error("core vector dropped without write");
   a_cap_rise: assert property (p_cap_rise) else $error("capture vector without pin edge");
endmodule // aux_timer_capture_reload_assertions

bind aux_timer_capture_reload aux_timer_capture_reload_assertions u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
   .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
   .i_capture_input_pin(i_capture_input_pin), .o_aux_wrap_vector(o_aux_wrap_vector),
   .o_capture_vector(o_capture_vector), .o_core_wrap_vector(o_core_wrap_vector),
   .o_core_toggle_out_pin(o_core_toggle_out_pin));

// ### verification/capture_pin_src.sv
// Slow external source driving the capture pin
`timescale 1ns/10ps
module capture_pin_src (
   // Clock
   input wire logic i_clk_sys,
   // Requested level
   input wire logic i_level,
   // Capture pin
   output logic o_pin
);
   logic pin_q = 1'b0;
   logic [3:0] hold_q = 4'h0;
   assign o_pin = pin_q;
   // Each level held nine clocks before it may change
   always @(posedge i_clk_sys) begin
      if (hold_q != 4'h8) begin
         hold_q <= hold_q + 4'h1;
      end else if (i_level != pin_q) begin
         pin_q <= i_level;
         hold_q <= 4'h0;
      end
   end
endmodule // capture_pin_src

// ### verification/aux_timer_capture_reload_tb_top.sv
// Self-checking bench for the auxiliary timer and capture/reload block
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module aux_timer_capture_reload_tb_top;
   import aux_timer_pkg::*;
   localparam logic [15:0] ADDRS [9] = '{ADDR_AUX_IRQ, ADDR_CAP_IRQ, ADDR_CORE_IRQ, ADDR_CORE_CTRL,
      ADDR_AUX_CTRL, ADDR_CORE_TIMER, ADDR_AUX_TIMER, ADDR_CAP_RELOAD, 16'h0000};
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic [15:0] i_addr = 16'h0000;
   logic [15:0] i_wr_data = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic pin_level = 1'b0;
   logic rd_d = 1'b0;
   logic pin;
   logic [15:0] o_rd_data;
   logic o_aux_wrap_vector;
   logic o_capture_vector;
   logic o_core_wrap_vector;
   logic o_core_toggle_out_pin;
   logic [15:0] exp_q [$];
   logic [15:0] exp_v;
   int fails = 0;
   int n_compared = 0;
   always #5 i_clk_sys = ~i_clk_sys;
   aux_timer_capture_reload dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
      .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_capture_input_pin(pin),
      .o_aux_wrap_vector(o_aux_wrap_vector), .o_capture_vector(o_capture_vector),
      .o_core_wrap_vector(o_core_wrap_vector), .o_core_toggle_out_pin(o_core_toggle_out_pin));
   capture_pin_src u_src (.i_clk_sys(i_clk_sys), .i_level(pin_level), .o_pin(pin));
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wr_data <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
   endtask
   task automatic complete_run;
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Read data stand one cycle after the strobe
   always @(posedge i_clk_sys) begin
      if (rd_d) begin
         exp_v = exp_q.pop_front();
         `CHK(o_rd_data, exp_v)
      end
      rd_d <= i_rd;
   end
   initial begin : watchdog
      repeat (30000) @(posedge i_clk_sys);
      fails++;
      complete_run();
   end
   initial begin : main
      logic [15:0] v;
      logic [15:0] cap_exp;
      logic hit;
      int n;
      void'($urandom(82));
      repeat (8) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      foreach (ADDRS[i]) rd(ADDRS[i], 16'h0000);
      wr(ADDR_AUX_CTRL, 16'hffff);
      rd(ADDR_AUX_CTRL, AUX_CTRL_MASK);
      wr(ADDR_AUX_CTRL, 16'h0000);
      wr(ADDR_AUX_IRQ, 16'hffff);
      rd(ADDR_AUX_IRQ, 16'h00ff);
      wr(ADDR_AUX_IRQ, 16'h0000);
      // Three ticks at every divisor, direction alternating
      for (int s = 0; s < 8; s++) begin
         v = 16'($urandom());
         wr(ADDR_AUX_TIMER, v);
         wr(ADDR_AUX_CTRL, {8'h00, s[0], 1'b1, 3'b000, s[2:0]});
         repeat (3 * (8 << s) - 1) @(posedge i_clk_sys);
         rd(ADDR_AUX_TIMER, s[0] ? v - 16'h0003 : v + 16'h0003);
         wr(ADDR_AUX_CTRL, 16'h0000);
      end
      wr(ADDR_AUX_IRQ, 16'h0040);
      wr(ADDR_AUX_TIMER, 16'hffff);
      wr(ADDR_AUX_CTRL, 16'h0040);
      repeat (20) @(posedge i_clk_sys);
      wr(ADDR_AUX_CTRL, 16'h0000);
      rd(ADDR_AUX_IRQ, 16'h00c0);
      #1 `CHK(o_aux_wrap_vector, 1'b1)
      wr(ADDR_AUX_IRQ, 16'h0080);
      repeat (2) @(posedge i_clk_sys);
      #1 `CHK(o_aux_wrap_vector, 1'b0)
      // Every edge code, capture and clear on and off
      cap_exp = 16'h0000;
      for (int e = 0; e < 4; e++) begin
         wr(ADDR_AUX_CTRL, {e[0] ^ e[1], e[0], e[1:0], 12'h000});
         for (int ph = 0; ph < 2; ph++) begin
            v = 16'($urandom());
            hit = ph ? e[1] : e[0];
            wr(ADDR_AUX_TIMER, v);
            wr(ADDR_CAP_IRQ, 16'h0000);
            pin_level <= ~pin_level;
            repeat (14) @(posedge i_clk_sys);
            if (hit && (e[0] ^ e[1])) cap_exp = v;
            rd(ADDR_CAP_IRQ, {8'h00, hit, 7'h00});
            rd(ADDR_AUX_TIMER, (hit && e[0]) ? 16'h0000 : v);
            rd(ADDR_CAP_RELOAD, cap_exp);
         end
      end
      wr(ADDR_CAP_IRQ, 16'h00c0);
      repeat (2) @(posedge i_clk_sys);
      #1 `CHK(o_capture_vector, 1'b1)
      wr(ADDR_CAP_IRQ, 16'h0000);
      repeat (2) @(posedge i_clk_sys);
      #1 `CHK(o_capture_vector, 1'b0)
      // Core reloads every 16 ticks: three wraps give latch rise, fall, rise
      wr(ADDR_CAP_RELOAD, 16'hfff0);
      wr(ADDR_CORE_IRQ, 16'h0040);
      for (int c = 3; c < 8; c++) begin
         n = (c[2] & c[0] ? 2 : 0) + (c[2] & c[1] ? 1 : 0);
         wr(ADDR_AUX_IRQ, 16'h0000);
         wr(ADDR_AUX_TIMER, 16'h0000);
         wr(ADDR_CORE_TIMER, 16'hffff);
         wr(ADDR_AUX_CTRL, {8'h00, 8'hc8 | 8'(c)});
         wr(ADDR_CORE_CTRL, 16'h8240);
         repeat (319) @(posedge i_clk_sys);
         rd(ADDR_AUX_TIMER, 16'(0 - n));
         rd(ADDR_AUX_IRQ, {8'h00, n != 0, 7'h00});
         rd(ADDR_CORE_IRQ, 16'h00c0);
         rd(ADDR_CAP_IRQ, 16'h0000);
         #1 `CHK(o_core_wrap_vector, 1'b1)
         `CHK(o_core_toggle_out_pin, 1'b1)
         // Software drops the latch while stopping the core
         wr(ADDR_CORE_CTRL, 16'h8200);
         #1 `CHK(o_core_toggle_out_pin, 1'b0)
         rd(ADDR_AUX_TIMER, 16'(0 - n));
      end
      repeat (3) @(posedge i_clk_sys);
      complete_run();
   end
endmodule // aux_timer_capture_reload_tb_top
